// >>> core/serial_ports_pkg.sv
/*
  constants shared by the device end and the host end of the serial ports link.
  assumes a single 50 MHz clock on both ends and an agreed baud rate.
*/
package serial_ports_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 50000000;
  localparam int BAUD_HZ = 115200;
  localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
  localparam logic [15:0] BIT_LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF_BIT = 16'(BIT_CYCLES / 2);
  // ************************************************************
  // framing
  // ************************************************************
  localparam int DATA_BITS = 8;
  localparam logic [3:0] FRAME_LAST = 4'h9; // start + 8 data + stop
  localparam logic [3:0] STOP_POS = 4'h9;
  localparam logic LINE_IDLE = 1'h1;
  localparam logic [9:0] SHIFT_RESET = 10'h3FF;
  localparam int GPIO_COUNT = 6;
  localparam logic [GPIO_COUNT-1:0] GPIO_RESET = 6'h00;
  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [1:0] {
    IDLE = 2'b00,
    RUN = 2'b01,
    DONE = 2'b10
  } ser_state_t;
endpackage : serial_ports_pkg

// >>> core/serial_link_if.sv
/*
  pin level link between the device end and the host end.
  assumes both ends share clk; lines not driven read as idle high (pull-ups).
*/
`timescale 1ns/10ps
`default_nettype none
interface serial_link_if;
  logic mainTx; // device to host data
  logic mainRx; // host to device data
  logic mainCts; // device permission, low = may send
  logic mainRts; // host permission, low = may send
  logic termReady; // host ready, low = ready
  logic ringInd; // device ring, low = ringing
  logic secTx;
  logic secRx;
  logic secCts;
  logic secRts;
  logic auxTx;
  logic auxRx;
  modport device (
    output mainTx, mainCts, ringInd, secTx, secCts, auxTx,
    input mainRx, mainRts, termReady, secRx, secRts, auxRx
  );
  modport host (
    input mainTx, mainCts, ringInd, secTx, secCts, auxTx,
    output mainRx, mainRts, termReady, secRx, secRts, auxRx
  );
endinterface : serial_link_if
`default_nettype wire

// >>> core/serial_device_end.sv
/*
  device end: three uarts (main, second, auxiliary), modem lines and six gpio pads.
  assumes host pins arrive asynchronously; open flow lines are pulled high by the link.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_device_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  serial_link_if.device link,
  input wire logic [2:0] txValid, // main, second, aux
  input wire logic [23:0] txData,
  output logic [2:0] txBusy,
  output logic [2:0] rxValid,
  output logic [23:0] rxData,
  output logic [2:0] rxFrameErr,
  input wire logic [1:0] rxReady, // main, second receive room
  input wire logic incomingCall,
  output logic hostReady,
  input wire logic [5:0] gpioDir, // 1 = output
  input wire logic [5:0] gpioWrite,
  input wire logic [5:0] gpioWrStrobe,
  input wire logic [1:0] gpioAltEn, // pin one terminal-ready, pin two ring
  input wire logic [5:0] gpioPadIn,
  output logic [5:0] gpioPadOut,
  output logic [5:0] gpioPadOe,
  output logic [5:0] gpioRead
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [11:0] syncA_ff, syncB_ff, nxt_syncA;
  always_comb begin
    nxt_syncA = {gpioPadIn, link.termReady, link.auxRx, link.secRts, link.secRx, link.mainRts, link.mainRx};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= 12'hFFF;
      syncB_ff <= 12'hFFF;
    end else if (clkEn) begin
      syncA_ff <= nxt_syncA;
      syncB_ff <= syncA_ff;
    end
  end
  // ************************************************************
  // uarts
  // ************************************************************
  logic [2:0] rxLine, txLine, txPermit;
  assign rxLine = {syncB_ff[4], syncB_ff[2], syncB_ff[0]};
  assign txPermit = {1'b1, ~syncB_ff[3], ~syncB_ff[1]};
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      serial_uart_core u_core (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .txValid(txValid[p]),
        .txData(txData[p*8 +: 8]),
        .txPermit(txPermit[p]),
        .txBusy(txBusy[p]),
        .txLine(txLine[p]),
        .rxLine(rxLine[p]),
        .rxValid(rxValid[p]),
        .rxData(rxData[p*8 +: 8]),
        .rxFrameErr(rxFrameErr[p])
      );
    end
  endgenerate
  // ************************************************************
  // modem lines and gpio
  // ************************************************************
  logic mainTx_ff, secTx_ff, auxTx_ff, mainCts_ff, secCts_ff, ring_ff, hostReady_ff;
  logic [5:0] gpioLevel_ff, nxt_gpioLevel, padOut_ff, nxt_padOut, padOe_ff, nxt_padOe, read_ff, nxt_read;
  logic nxt_ring, nxt_hostReady;
  localparam logic LINE_IDLE_C = serial_ports_pkg::LINE_IDLE;
  always_comb begin
    nxt_gpioLevel = gpioLevel_ff;
    for (int i = 0; i < 6; i++) begin
      if (gpioWrStrobe[i] && gpioDir[i]) begin
        nxt_gpioLevel[i] = gpioWrite[i];
      end
    end
    nxt_padOe = gpioDir;
    nxt_padOut = nxt_gpioLevel;
    nxt_read = syncB_ff[11:6];
    for (int i = 0; i < 6; i++) begin
      if (gpioDir[i]) begin
        nxt_read[i] = nxt_gpioLevel[i];
      end
    end
    nxt_ring = ~incomingCall;
    if (gpioAltEn[1]) begin
      nxt_padOe[1] = 1'b1;
      nxt_padOut[1] = nxt_ring;
      nxt_read[1] = nxt_ring;
    end
    nxt_hostReady = ~syncB_ff[5];
    if (gpioAltEn[0]) begin
      nxt_padOe[0] = 1'b0;
      nxt_hostReady = ~syncB_ff[6];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mainTx_ff <= LINE_IDLE_C;
      secTx_ff <= LINE_IDLE_C;
      auxTx_ff <= LINE_IDLE_C;
      mainCts_ff <= 1'h1;
      secCts_ff <= 1'h1;
      ring_ff <= 1'h1;
      hostReady_ff <= 1'h0;
      gpioLevel_ff <= serial_ports_pkg::GPIO_RESET;
      padOut_ff <= serial_ports_pkg::GPIO_RESET;
      padOe_ff <= serial_ports_pkg::GPIO_RESET;
      read_ff <= serial_ports_pkg::GPIO_RESET;
    end else if (clkEn) begin
      mainTx_ff <= txLine[0];
      secTx_ff <= txLine[1];
      auxTx_ff <= txLine[2];
      mainCts_ff <= ~rxReady[0];
      secCts_ff <= ~rxReady[1];
      ring_ff <= nxt_ring;
      hostReady_ff <= nxt_hostReady;
      gpioLevel_ff <= nxt_gpioLevel;
      padOut_ff <= nxt_padOut;
      padOe_ff <= nxt_padOe;
      read_ff <= nxt_read;
    end
  end
  assign link.mainTx = mainTx_ff;
  assign link.secTx = secTx_ff;
  assign link.auxTx = auxTx_ff;
  assign link.mainCts = mainCts_ff;
  assign link.secCts = secCts_ff;
  assign link.ringInd = ring_ff;
  assign hostReady = hostReady_ff;
  assign gpioPadOut = padOut_ff;
  assign gpioPadOe = padOe_ff;
  assign gpioRead = read_ff;
endmodule : serial_device_end

// ************************************************************
// one uart: transmitter and receiver sharing the frame format
// ************************************************************
module serial_uart_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txPermit,
  output logic txBusy,
  output logic txLine,
  input wire logic rxLine,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxFrameErr
);
  serial_ports_pkg::ser_state_t txState_ff, nxt_txState, rxState_ff, nxt_rxState;
  logic [15:0] txCnt_ff, nxt_txCnt, rxCnt_ff, nxt_rxCnt;
  logic [3:0] txBit_ff, nxt_txBit, rxBit_ff, nxt_rxBit;
  logic [9:0] txShift_ff, nxt_txShift, rxShift_ff, nxt_rxShift;
  logic rxValid_ff, nxt_rxValid, rxErr_ff, nxt_rxErr;
  // next state of both directions
  always_comb begin
    nxt_txState = txState_ff;
    nxt_txCnt = txCnt_ff;
    nxt_txBit = txBit_ff;
    nxt_txShift = txShift_ff;
    case (txState_ff)
      serial_ports_pkg::IDLE: begin
        if (txValid && txPermit) begin
          nxt_txShift = {1'b1, txData, 1'b0};
          nxt_txCnt = 16'h0000;
          nxt_txBit = 4'h0;
          nxt_txState = serial_ports_pkg::RUN;
        end
      end
      serial_ports_pkg::RUN: begin
        if (txCnt_ff == serial_ports_pkg::BIT_LAST) begin
          nxt_txCnt = 16'h0000;
          nxt_txShift = {1'b1, txShift_ff[9:1]};
          if (txBit_ff == serial_ports_pkg::FRAME_LAST) begin
            nxt_txState = serial_ports_pkg::IDLE;
          end else begin
            nxt_txBit = txBit_ff + 4'h1;
          end
        end else begin
          nxt_txCnt = txCnt_ff + 16'h0001;
        end
      end
      default: nxt_txState = serial_ports_pkg::IDLE;
    endcase
    nxt_rxState = rxState_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxBit = rxBit_ff;
    nxt_rxShift = rxShift_ff;
    nxt_rxValid = 1'b0;
    nxt_rxErr = 1'b0;
    case (rxState_ff)
      serial_ports_pkg::IDLE: begin
        if (!rxLine) begin
          nxt_rxCnt = serial_ports_pkg::HALF_BIT; // sample mid bit
          nxt_rxBit = 4'h0;
          nxt_rxState = serial_ports_pkg::RUN;
        end
      end
      serial_ports_pkg::RUN: begin
        if (rxCnt_ff == serial_ports_pkg::BIT_LAST) begin
          nxt_rxCnt = 16'h0000;
          nxt_rxShift = {rxLine, rxShift_ff[9:1]};
          if (rxBit_ff == 4'h0 && rxLine) begin
            nxt_rxState = serial_ports_pkg::IDLE; // false start
          end else if (rxBit_ff == serial_ports_pkg::STOP_POS) begin
            nxt_rxState = serial_ports_pkg::DONE;
          end else begin
            nxt_rxBit = rxBit_ff + 4'h1;
          end
        end else begin
          nxt_rxCnt = rxCnt_ff + 16'h0001;
        end
      end
      serial_ports_pkg::DONE: begin
        nxt_rxValid = rxShift_ff[9];
        nxt_rxErr = ~rxShift_ff[9];
        nxt_rxState = serial_ports_pkg::IDLE;
      end
      default: nxt_rxState = serial_ports_pkg::IDLE;
    endcase
  end
  // state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txState_ff <= serial_ports_pkg::IDLE;
      txCnt_ff <= 16'h0000;
      txBit_ff <= 4'h0;
      txShift_ff <= serial_ports_pkg::SHIFT_RESET;
      rxState_ff <= serial_ports_pkg::IDLE;
      rxCnt_ff <= 16'h0000;
      rxBit_ff <= 4'h0;
      rxShift_ff <= serial_ports_pkg::SHIFT_RESET;
      rxValid_ff <= 1'b0;
      rxErr_ff <= 1'b0;
    end else if (clkEn) begin
      txState_ff <= nxt_txState;
      txCnt_ff <= nxt_txCnt;
      txBit_ff <= nxt_txBit;
      txShift_ff <= nxt_txShift;
      rxState_ff <= nxt_rxState;
      rxCnt_ff <= nxt_rxCnt;
      rxBit_ff <= nxt_rxBit;
      rxShift_ff <= nxt_rxShift;
      rxValid_ff <= nxt_rxValid;
      rxErr_ff <= nxt_rxErr;
    end
  end
  assign txLine = txShift_ff[0];
  assign txBusy = txState_ff[0]; // run is the only busy state, straight from the flop
  assign rxValid = rxValid_ff;
  assign rxFrameErr = rxErr_ff;
  assign rxData = rxShift_ff[8:1];
endmodule : serial_uart_core
`default_nettype wire

// >>> core/serial_host_end.sv
/*
  host end: logic-level uarts facing the device's three ports plus modem lines.
  assumes the shared clk and device pins arriving through the link interface.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_host_end (
  input wire logic clk,
  input wire logic rst,
  input wire logic clkEn,
  serial_link_if.host link,
  input wire logic [2:0] txValid,
  input wire logic [23:0] txData,
  output logic [2:0] txBusy,
  output logic [2:0] rxValid,
  output logic [23:0] rxData,
  output logic [2:0] rxFrameErr,
  input wire logic [1:0] rxReady,
  input wire logic terminalReady,
  input wire logic deviceBooting,
  output logic ringSeen
);
  // ************************************************************
  // synchronisers for device pins
  // ************************************************************
  logic [5:0] syncA_ff, syncB_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= 6'h3F;
      syncB_ff <= 6'h3F;
    end else if (clkEn) begin
      syncA_ff <= {link.ringInd, link.auxTx, link.secCts, link.secTx, link.mainCts, link.mainTx};
      syncB_ff <= syncA_ff;
    end
  end
  // ************************************************************
  // uarts
  // ************************************************************
  logic [2:0] txLine, permit;
  assign permit = {1'b1, ~syncB_ff[3], ~syncB_ff[1]};
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_port
      serial_uart_core u_core (
        .clk(clk),
        .rst(rst),
        .clkEn(clkEn),
        .txValid(txValid[p] && !(p == 1 && deviceBooting)),
        .txData(txData[p*8 +: 8]),
        .txPermit(permit[p]),
        .txBusy(txBusy[p]),
        .txLine(txLine[p]),
        .rxLine(syncB_ff[2*p]),
        .rxValid(rxValid[p]),
        .rxData(rxData[p*8 +: 8]),
        .rxFrameErr(rxFrameErr[p])
      );
    end
  endgenerate
  // ************************************************************
  // pin drivers
  // ************************************************************
  logic mainRx_ff, secRx_ff, auxRx_ff, mainRts_ff, secRts_ff, term_ff, ring_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mainRx_ff <= 1'h1;
      secRx_ff <= 1'h1;
      auxRx_ff <= 1'h1;
      mainRts_ff <= 1'h1;
      secRts_ff <= 1'h1;
      term_ff <= 1'h1;
      ring_ff <= 1'h0;
    end else if (clkEn) begin
      mainRx_ff <= txLine[0];
      secRx_ff <= txLine[1];
      auxRx_ff <= txLine[2];
      mainRts_ff <= ~rxReady[0];
      secRts_ff <= ~rxReady[1];
      term_ff <= ~terminalReady;
      ring_ff <= ~syncB_ff[5];
    end
  end
  assign link.mainRx = mainRx_ff;
  assign link.secRx = secRx_ff;
  assign link.auxRx = auxRx_ff;
  assign link.mainRts = mainRts_ff;
  assign link.secRts = secRts_ff;
  assign link.termReady = term_ff;
  assign ringSeen = ring_ff;
endmodule : serial_host_end
`default_nettype wire

// >>> bench/serial_ports_assertions.sv
/*
  pin checks on the link between the device end and the host end.
  assumes one clock for both ends, clkEn held high, package baud rate.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_ports_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic mainTx,
  input wire logic mainRx,
  input wire logic mainCts,
  input wire logic mainRts,
  input wire logic secTx,
  input wire logic auxTx,
  input wire logic ringInd
);
  localparam int BIT = serial_ports_pkg::BIT_CYCLES;
  localparam int IDLE_MIN = 11 * BIT;
  logic [15:0] txRun_ff, rxRun_ff, nxt_txRun, nxt_rxRun;
  logic txLast_ff, rxLast_ff;
  // ************************************************************
  // run length of each main data line
  // ************************************************************
  // restart on a change, saturate so a long idle never wraps
  always_comb begin
    nxt_txRun = (mainTx != txLast_ff) ? 16'h1 : txRun_ff + {15'h0, txRun_ff != 16'hFFFF};
    nxt_rxRun = (mainRx != rxLast_ff) ? 16'h1 : rxRun_ff + {15'h0, rxRun_ff != 16'hFFFF};
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txRun_ff <= 16'hFFFF;
      rxRun_ff <= 16'hFFFF;
      txLast_ff <= 1'h1;
      rxLast_ff <= 1'h1;
    end else begin
      txRun_ff <= nxt_txRun;
      rxRun_ff <= nxt_rxRun;
      txLast_ff <= mainTx;
      rxLast_ff <= mainRx;
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // partner refuses for a while and the line has been idle for over a frame
  sequence s_txHeld;
    mainRts[*5] ##0 (txRun_ff > IDLE_MIN);
  endsequence
  sequence s_rxHeld;
    mainCts[*5] ##0 (rxRun_ff > IDLE_MIN);
  endsequence
  property p_rstIdle;
    $fell(rst) |-> mainTx && secTx && auxTx && ringInd && mainCts;
  endproperty
  property p_mainStart;
    $fell(mainTx) |-> !mainTx[*8];
  endproperty
  property p_secStart;
    $fell(secTx) |-> !secTx[*8];
  endproperty
  property p_auxStart;
    $fell(auxTx) |-> !auxTx[*8];
  endproperty
  property p_txBit;
    (mainTx != txLast_ff) |-> txRun_ff >= BIT;
  endproperty
  property p_rxBit;
    (mainRx != rxLast_ff) |-> rxRun_ff >= BIT;
  endproperty
  property p_rtsBlocks;
    s_txHeld |=> mainTx;
  endproperty
  property p_ctsBlocks;
    s_rxHeld |=> mainRx;
  endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("lines not idle after reset");
  a_mainStart: assert property (p_mainStart) else $error("short main bit");
  a_secStart: assert property (p_secStart) else $error("short second bit");
  a_auxStart: assert property (p_auxStart) else $error("short aux bit");
  a_txBit: assert property (p_txBit) else $error("main transmit bit too short");
  a_rxBit: assert property (p_rxBit) else $error("main receive bit too short");
  a_rtsBlocks: assert property (p_rtsBlocks) else $error("device sent without grant");
  a_ctsBlocks: assert property (p_ctsBlocks) else $error("host sent without grant");
endmodule : serial_ports_assertions
`default_nettype wire

// >>> bench/module_serial_ports_gpio_tb_top.sv
/*
  bench joining the device end and the host end over the pin link.
  assumes the 50 MHz clock and the package baud rate.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failCount++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module module_serial_ports_gpio_tb_top;
  typedef struct packed {logic toHost; logic [1:0] port; logic [7:0] val;} row_t;
  localparam row_t ROWS [6] = '{'{1'h1, 2'h0, 8'hA5}, '{1'h0, 2'h0, 8'h5A}, '{1'h1, 2'h1, 8'h81},
                                '{1'h0, 2'h1, 8'h7E}, '{1'h1, 2'h2, 8'h00}, '{1'h0, 2'h2, 8'hFF}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [2:0] dTxValid = 3'h0, hTxValid = 3'h0, dTxBusy, hTxBusy, dRxValid, hRxValid;
  logic [23:0] dTxData = 24'h0, hTxData = 24'h0, dRxData, hRxData;
  logic [1:0] dRxReady = 2'h3, hRxReady = 2'h3, gpioAltEn = 2'h0;
  logic incomingCall = 1'h0, terminalReady = 1'h0, deviceBooting = 1'h0, hostReady, ringSeen;
  logic [5:0] gpioDir = 6'h0, gpioWrite = 6'h0, gpioWrStrobe = 6'h0, gpioPadIn = 6'h0;
  logic [5:0] gpioPadOut, gpioPadOe, gpioRead;
  logic [2:0] dRxFrameErr, hRxFrameErr;
  logic [5:0] errSeen = 6'h00;
  int failCount = 0, checked = 0;
  serial_link_if link ();
  serial_device_end serial_device_end_i (.clk(clk), .rst(rst), .clkEn(1'h1), .link(link),
    .txValid(dTxValid), .txData(dTxData), .txBusy(dTxBusy), .rxValid(dRxValid), .rxData(dRxData),
    .rxFrameErr(dRxFrameErr), .rxReady(dRxReady), .incomingCall(incomingCall), .hostReady(hostReady),
    .gpioDir(gpioDir), .gpioWrite(gpioWrite), .gpioWrStrobe(gpioWrStrobe), .gpioAltEn(gpioAltEn),
    .gpioPadIn(gpioPadIn), .gpioPadOut(gpioPadOut), .gpioPadOe(gpioPadOe), .gpioRead(gpioRead));
  serial_host_end serial_host_end_i (.clk(clk), .rst(rst), .clkEn(1'h1), .link(link),
    .txValid(hTxValid), .txData(hTxData), .txBusy(hTxBusy), .rxValid(hRxValid), .rxData(hRxData),
    .rxFrameErr(hRxFrameErr), .rxReady(hRxReady), .terminalReady(terminalReady), .deviceBooting(deviceBooting),
    .ringSeen(ringSeen));
  serial_ports_assertions serial_ports_assertions_i (.clk(clk), .rst(rst), .mainTx(link.mainTx),
    .mainRx(link.mainRx), .mainCts(link.mainCts), .mainRts(link.mainRts), .secTx(link.secTx),
    .auxTx(link.auxTx), .ringInd(link.ringInd));
  // ************************************************************
  // helpers
  // ************************************************************
  always #10 clk = ~clk;
  // collect any framing error seen by either end once out of reset
  always @(posedge clk) begin
    if (!rst) begin
      errSeen <= errSeen | {hRxFrameErr, dRxFrameErr};
    end
  end
  task automatic giveVerdict;
    $display("checked %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : giveVerdict
  // raise a request and drop it once the frame is under way
  task automatic send(input logic toHost, input int p, input logic [7:0] v);
    int n;
    n = 0;
    dTxData[8*p+:8] = v;
    hTxData[8*p+:8] = v;
    dTxValid[p] = toHost;
    hTxValid[p] = !toHost;
    while ((toHost ? dTxBusy[p] : hTxBusy[p]) !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      failCount++;
    end
    dTxValid = 3'h0;
    hTxValid = 3'h0;
  endtask : send
  // wait for the far end to deliver a byte, then compare it
  task automatic recv(input logic toHost, input int p, input logic [7:0] v);
    int n;
    n = 0;
    while ((toHost ? hRxValid[p] : dRxValid[p]) !== 1'h1 && n < 6000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 6000) begin
      failCount++;
    end
    `CHK(toHost ? hRxData[8*p+:8] : dRxData[8*p+:8], v)
  endtask : recv
  // ************************************************************
  // tests
  // ************************************************************
  // watchdog: about 38k cycles of tests, cut off well beyond
  initial begin
    repeat (60000) @(posedge clk);
    failCount++;
    giveVerdict();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'h0;
    `CHK(link.mainTx, 1'h1)
    `CHK(link.ringInd, 1'h1)
    `CHK(hostReady, 1'h0)
    $display("test reset done");
    repeat (10) @(negedge clk);
    // one frame per row, each port in both directions
    for (int i = 0; i < 6; i++) begin
      send(ROWS[i].toHost, int'(ROWS[i].port), ROWS[i].val);
      recv(ROWS[i].toHost, int'(ROWS[i].port), ROWS[i].val);
    end
    $display("test rows done");
    // both users withhold permission, requests must wait
    hRxReady = 2'h2;
    dRxReady = 2'h2;
    repeat (10) @(negedge clk);
    dTxValid[0] = 1'h1;
    hTxValid[0] = 1'h1;
    repeat (5000) @(negedge clk);
    `CHK(dTxBusy[0], 1'h0)
    `CHK(hTxBusy[0], 1'h0)
    dTxValid = 3'h0;
    hTxValid = 3'h0;
    hRxReady = 2'h3;
    dRxReady = 2'h3;
    repeat (10) @(negedge clk);
    send(1'h1, 0, 8'hC3);
    recv(1'h1, 0, 8'hC3);
    send(1'h0, 0, 8'h3C);
    recv(1'h0, 0, 8'h3C);
    $display("test flow done");
    // second port held back while the device boots
    deviceBooting = 1'h1;
    hTxValid[1] = 1'h1;
    repeat (20) @(negedge clk);
    `CHK(hTxBusy[1], 1'h0)
    hTxValid = 3'h0;
    deviceBooting = 1'h0;
    $display("test boot done");
    // modem lines, ring carried on pin two with all pins set as outputs
    terminalReady = 1'h1;
    incomingCall = 1'h1;
    gpioAltEn = 2'h2;
    gpioDir = 6'h3F;
    repeat (8) @(negedge clk);
    `CHK(hostReady, 1'h1)
    `CHK(ringSeen, 1'h1)
    `CHK(gpioPadOe[1], 1'h1)
    `CHK(gpioPadOut[1], 1'h0)
    terminalReady = 1'h0;
    incomingCall = 1'h0;
    gpioAltEn = 2'h1;
    repeat (8) @(negedge clk);
    `CHK(ringSeen, 1'h0)
    `CHK(hostReady, 1'h1)
    `CHK(gpioPadOe[0], 1'h0)
    gpioPadIn = 6'h01;
    repeat (8) @(negedge clk);
    `CHK(hostReady, 1'h0)
    $display("test modem done");
    // plain pins: inputs follow the pad, outputs keep the written level
    gpioAltEn = 2'h0;
    gpioDir = 6'h00;
    gpioPadIn = 6'h2A;
    repeat (4) @(negedge clk);
    `CHK(gpioRead, 6'h2A)
    `CHK(gpioPadOe, 6'h00)
    gpioDir = 6'h3F;
    gpioWrite = 6'h1B;
    gpioWrStrobe = 6'h3F;
    @(negedge clk);
    gpioWrStrobe = 6'h00;
    `CHK(gpioPadOut, 6'h1B)
    `CHK(gpioRead, 6'h1B)
    `CHK(gpioPadOe, 6'h3F)
    gpioPadIn = 6'h00;
    repeat (4) @(negedge clk);
    `CHK(gpioRead, 6'h1B)
    `CHK(errSeen, 6'h00)
    $display("test gpio done");
    giveVerdict();
  end
endmodule : module_serial_ports_gpio_tb_top
`undef CHK
`default_nettype wire
